// ==== logic/fdft_consts.svh ====
`ifndef FDFT_CONSTS_SVH
`define FDFT_CONSTS_SVH
// ----------------------------------------------------------------
// Framing
// ----------------------------------------------------------------
`define FDFT_SPC        32
`define FDFT_NCH        8
`define FDFT_CH_VA      3'h0
`define FDFT_CH_VB      3'h1
`define FDFT_CH_VC      3'h2
`define FDFT_CH_VAB     3'h3
`define FDFT_CH_LAST    3'h7
`define FDFT_IDX_LAST   5'h1f
`define FDFT_WORD_W     19
`define FDFT_FIFO_DEPTH 4
`define FDFT_CORDIC_IT  12
// ----------------------------------------------------------------
// Timing and levels
// ----------------------------------------------------------------
`define FDFT_CLK_HZ     200000000
`define FDFT_NOM_HZ_50  50
`define FDFT_NOM_HZ_60  60
`define FDFT_NOM_TICKS(f) (`FDFT_CLK_HZ / ((f) * `FDFT_SPC))
`define FDFT_VMIN_MV    2000
`define FDFT_LSB_UV     10000
`define FDFT_VMIN_CODE  (`FDFT_VMIN_MV * 1000 / `FDFT_LSB_UV)
`endif

// ==== logic/fdft_pkg.sv ====
package fdft_pkg;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    fdft_rate_nom   = 2'h0,
    fdft_rate_track = 2'h1,
    fdft_rate_hold  = 2'h3
  } fdft_rate_e;

  typedef enum logic [1:0] {
    fdft_cs_idle = 2'h0,
    fdft_cs_run  = 2'h1,
    fdft_cs_out  = 2'h3
  } fdft_cs_e;
endpackage

// ==== logic/fdft_stream_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface fdft_stream_if #(parameter int W = 19);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ==== logic/fdft_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module fdft_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             wr_valid,
  output var  logic             wr_ready,
  fdft_stream_if.src            rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  logic             full_r;
  logic             empty_r;

  // ----------------------------------------------------------------
  // Pointers and flags
  // ----------------------------------------------------------------
  wire logic        push   = wr_valid && !full_r;
  wire logic        pop    = rd.valid && rd.ready;
  wire logic [AW:0] wp_nxt = wp_r + (AW+1)'(push);
  wire logic [AW:0] rp_nxt = rp_r + (AW+1)'(pop);

  assign wr_ready = !full_r;
  assign rd.valid = !empty_r;
  assign rd.data  = mem[rp_r[AW-1:0]];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_r    <= '0;
      rp_r    <= '0;
      full_r  <= 1'b0;
      empty_r <= 1'b1;
    end else begin
      wp_r    <= wp_nxt;
      rp_r    <= rp_nxt;
      full_r  <= (wp_nxt[AW] != rp_nxt[AW]) &&
                 (wp_nxt[AW-1:0] == rp_nxt[AW-1:0]);
      empty_r <= wp_nxt == rp_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= wr_data;
    end
  end
endmodule
`default_nettype wire

// ==== logic/fdft_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fdft_consts.svh"
module fdft_top #(
  parameter int          IT           = `FDFT_CORDIC_IT,
  parameter int          FIFO_DEPTH   = `FDFT_FIFO_DEPTH,
  parameter logic [23:0] NOM_TICKS_50 =
    24'(`FDFT_NOM_TICKS(`FDFT_NOM_HZ_50)),
  parameter logic [23:0] NOM_TICKS_60 =
    24'(`FDFT_NOM_TICKS(`FDFT_NOM_HZ_60)),
  parameter logic [15:0] VMIN_CODE    = 16'(`FDFT_VMIN_CODE)
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               ref_sel_ab,
  input  wire logic               nominal_60,
  input  wire logic               in_valid,
  output var  logic               in_ready,
  input  wire logic [2:0]         in_ch,
  input  wire logic [15:0]        in_data,
  output logic                    sample_req,
  output logic [1:0]              rate_mode,
  output logic [23:0]             freq_period,
  output logic                    freq_valid,
  output logic                    ph_valid,
  output logic [2:0]              ph_ch,
  output logic signed [23:0]      ph_re,
  output logic signed [23:0]      ph_im,
  output logic [25:0]             ph_mag,
  output logic [15:0]             ph_ang
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic signed [15:0] cos_oct(input logic [3:0] r);
    unique case (r)
      4'h0:    cos_oct = 16'sh7fff;
      4'h1:    cos_oct = 16'sh7d89;
      4'h2:    cos_oct = 16'sh7641;
      4'h3:    cos_oct = 16'sh6a6d;
      4'h4:    cos_oct = 16'sh5a82;
      4'h5:    cos_oct = 16'sh471c;
      4'h6:    cos_oct = 16'sh30fb;
      4'h7:    cos_oct = 16'sh18f9;
      default: cos_oct = 16'sh0000;
    endcase
  endfunction

  function automatic logic signed [15:0] tw_cos(input logic [4:0] k);
    logic [3:0]         r;
    logic signed [15:0] a;
    r = k[3] ? 4'h8 - {1'b0, k[2:0]} : {1'b0, k[2:0]};
    a = cos_oct(r);
    tw_cos = (k[4] ^ k[3]) ? -a : a;
  endfunction

  function automatic logic [15:0] atan_lut(input logic [3:0] i);
    unique case (i)
      4'h0:    atan_lut = 16'h2000;
      4'h1:    atan_lut = 16'h12e4;
      4'h2:    atan_lut = 16'h09fb;
      4'h3:    atan_lut = 16'h0511;
      4'h4:    atan_lut = 16'h028b;
      4'h5:    atan_lut = 16'h0146;
      4'h6:    atan_lut = 16'h00a3;
      4'h7:    atan_lut = 16'h0051;
      4'h8:    atan_lut = 16'h0029;
      4'h9:    atan_lut = 16'h0014;
      4'ha:    atan_lut = 16'h000a;
      4'hb:    atan_lut = 16'h0005;
      4'hc:    atan_lut = 16'h0003;
      4'hd:    atan_lut = 16'h0001;
      4'he:    atan_lut = 16'h0001;
      default: atan_lut = 16'h0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Input buffer
  // ----------------------------------------------------------------
  fdft_stream_if #(.W(`FDFT_WORD_W)) q_if ();

  fdft_fifo #(
    .WIDTH (`FDFT_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .nrst     (nrst),
    .wr_data  ({in_ch, in_data}),
    .wr_valid (in_valid),
    .wr_ready (in_ready),
    .rd       (q_if.src)
  );

  logic signed [15:0]     hist [`FDFT_NCH * `FDFT_SPC];
  logic signed [23:0]     re_acc [`FDFT_NCH];
  logic signed [23:0]     im_acc [`FDFT_NCH];
  logic [4:0]             idx_r;
  logic                   primed_r;
  logic [15:0]            peak_r [3];
  logic [2:0]             vok_r;
  logic                   neg_r;
  logic                   edge_seen_r;
  logic                   ref_sel_r;
  logic [23:0]            per_cnt_r;
  logic [23:0]            interval_r;
  logic [23:0]            tmr_r;
  fdft_pkg::fdft_rate_e   rate_r;
  fdft_pkg::fdft_cs_e     cs_r;
  logic signed [25:0]     cx_r;
  logic signed [25:0]     cy_r;
  logic [15:0]            cz_r;
  logic [3:0]             it_r;
  logic [2:0]             c_ch_r;
  logic signed [23:0]     c_re_r;
  logic signed [23:0]     c_im_r;
  logic [15:0]            va_ang_r;

  // ----------------------------------------------------------------
  // Sliding DFT datapath
  // ----------------------------------------------------------------
  assign q_if.ready = cs_r == fdft_pkg::fdft_cs_idle;

  wire logic              pop    = q_if.valid && q_if.ready;
  wire logic [2:0]        s_ch   = q_if.data[18:16];
  wire logic signed [15:0] s_x   = q_if.data[15:0];
  wire logic [7:0]        h_addr = {s_ch, idx_r};
  wire logic signed [15:0] h_old = primed_r ? hist[h_addr] : 16'sh0000;
  wire logic signed [16:0] dlt   = 17'(s_x) - 17'(h_old);
  wire logic signed [15:0] tc    = tw_cos(idx_r);
  wire logic signed [15:0] ts    = tw_cos(idx_r - 5'h08);
  wire logic signed [32:0] p_re  = 33'(dlt) * 33'(tc);
  wire logic signed [32:0] p_im  = 33'(dlt) * 33'(ts);
  wire logic signed [17:0] t_re  = p_re[32:15];
  wire logic signed [17:0] t_im  = p_im[32:15];
  wire logic signed [23:0] re_new = re_acc[s_ch] + 24'(t_re);
  wire logic signed [23:0] im_new = im_acc[s_ch] - 24'(t_im);
  wire logic              last_ch = pop && s_ch == `FDFT_CH_LAST;
  wire logic              cyc_end = last_ch && idx_r == `FDFT_IDX_LAST;

  always_ff @(posedge clk) begin
    if (pop) begin
      hist[h_addr] <= s_x;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < `FDFT_NCH; k++) begin
        re_acc[k] <= 24'sh0;
        im_acc[k] <= 24'sh0;
      end
    end else if (pop) begin
      re_acc[s_ch] <= re_new;
      im_acc[s_ch] <= im_new;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idx_r    <= 5'h00;
      primed_r <= 1'b0;
    end else if (last_ch) begin
      idx_r    <= idx_r + 5'h01;
      primed_r <= primed_r || cyc_end;
    end
  end

  // ----------------------------------------------------------------
  // Voltage presence per cycle
  // ----------------------------------------------------------------
  wire logic [15:0] ax = s_x[15] ? 16'(-s_x) : 16'(s_x);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < 3; k++) begin
        peak_r[k] <= 16'h0000;
      end
      vok_r <= 3'h0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (cyc_end) begin
          peak_r[k] <= 16'h0000;
          vok_r[k]  <= peak_r[k] >= VMIN_CODE;
        end else if (pop && s_ch == 3'(k) && ax > peak_r[k]) begin
          peak_r[k] <= ax;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Zero crossing and period
  // ----------------------------------------------------------------
  wire logic [2:0]  ref_ch  = ref_sel_ab ? `FDFT_CH_VAB : `FDFT_CH_VA;
  wire logic        ref_hit = pop && s_ch == ref_ch;
  wire logic        ref_chg = ref_sel_ab != ref_sel_r;
  wire logic        xing    = ref_hit && neg_r && !s_x[15] && vok_r[0] &&
                              !ref_chg;
  wire logic        new_per = xing && edge_seen_r;
  wire logic [23:0] per_div = {5'h00, per_cnt_r[23:5]};
  wire logic [23:0] nom_tk  = nominal_60 ? NOM_TICKS_60 : NOM_TICKS_50;
  wire fdft_pkg::fdft_rate_e rate_nxt =
    vok_r[0]              ? fdft_pkg::fdft_rate_track :
    (vok_r[1] | vok_r[2]) ? fdft_pkg::fdft_rate_hold  :
                            fdft_pkg::fdft_rate_nom;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      neg_r       <= 1'b0;
      edge_seen_r <= 1'b0;
      ref_sel_r   <= 1'b0;
      per_cnt_r   <= 24'h000000;
    end else begin
      ref_sel_r <= ref_sel_ab;
      if (ref_hit) begin
        neg_r <= s_x[15];
      end else if (ref_chg) begin
        neg_r <= 1'b0;
      end
      edge_seen_r <= vok_r[0] && !ref_chg && (edge_seen_r || xing);
      if (xing) begin
        per_cnt_r <= 24'h000001;
      end else if (per_cnt_r != 24'hffffff) begin
        per_cnt_r <= per_cnt_r + 24'h000001;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      freq_period <= 24'h000000;
      freq_valid  <= 1'b0;
    end else if (!vok_r[0]) begin
      freq_valid  <= 1'b0;
    end else if (new_per) begin
      freq_period <= per_cnt_r;
      freq_valid  <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sampling rate control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rate_r     <= fdft_pkg::fdft_rate_nom;
      interval_r <= NOM_TICKS_50;
    end else begin
      rate_r <= rate_nxt;
      if (rate_nxt == fdft_pkg::fdft_rate_nom) begin
        interval_r <= nom_tk;
      end else if (rate_nxt == fdft_pkg::fdft_rate_track && new_per &&
                   per_div != 24'h000000) begin
        interval_r <= per_div;
      end
    end
  end
  // the hold state leaves interval_r untouched

  assign rate_mode = rate_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tmr_r      <= 24'h000000;
      sample_req <= 1'b0;
    end else if (tmr_r == 24'h000000) begin
      tmr_r      <= interval_r - 24'h000001;
      sample_req <= 1'b1;
    end else begin
      tmr_r      <= tmr_r - 24'h000001;
      sample_req <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Magnitude and angle
  // ----------------------------------------------------------------
  wire logic signed [25:0] nx    = 26'(re_new);
  wire logic signed [25:0] ny    = 26'(im_new);
  wire logic signed [25:0] xs    = cx_r >>> it_r;
  wire logic signed [25:0] ys    = cy_r >>> it_r;
  wire logic [15:0]        at    = atan_lut(it_r);
  wire logic               y_neg = cy_r[25];
  wire logic               is_va = c_ch_r == `FDFT_CH_VA;
  wire logic [15:0]        ref_a = is_va ? cz_r : va_ang_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_r   <= fdft_pkg::fdft_cs_idle;
      cx_r   <= 26'sh0;
      cy_r   <= 26'sh0;
      cz_r   <= 16'h0000;
      it_r   <= 4'h0;
      c_ch_r <= 3'h0;
      c_re_r <= 24'sh0;
      c_im_r <= 24'sh0;
    end else begin
      unique case (cs_r)
        fdft_pkg::fdft_cs_idle: begin
          if (pop) begin
            cs_r   <= fdft_pkg::fdft_cs_run;
            it_r   <= 4'h0;
            c_ch_r <= s_ch;
            c_re_r <= re_new;
            c_im_r <= im_new;
            cx_r   <= re_new[23] ? -nx : nx;
            cy_r   <= re_new[23] ? -ny : ny;
            cz_r   <= re_new[23] ? 16'h8000 : 16'h0000;
          end
        end
        fdft_pkg::fdft_cs_run: begin
          cx_r <= y_neg ? cx_r - ys : cx_r + ys;
          cy_r <= y_neg ? cy_r + xs : cy_r - xs;
          cz_r <= y_neg ? cz_r - at : cz_r + at;
          it_r <= it_r + 4'h1;
          if (it_r == 4'(IT - 1)) begin
            cs_r <= fdft_pkg::fdft_cs_out;
          end
        end
        fdft_pkg::fdft_cs_out: begin
          cs_r <= fdft_pkg::fdft_cs_idle;
        end
        default: begin
          cs_r <= fdft_pkg::fdft_cs_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_valid <= 1'b0;
      ph_ch    <= 3'h0;
      ph_re    <= 24'sh0;
      ph_im    <= 24'sh0;
      ph_mag   <= 26'h0;
      ph_ang   <= 16'h0000;
      va_ang_r <= 16'h0000;
    end else begin
      ph_valid <= cs_r == fdft_pkg::fdft_cs_out;
      if (cs_r == fdft_pkg::fdft_cs_out) begin
        ph_ch  <= c_ch_r;
        ph_re  <= c_re_r;
        ph_im  <= c_im_r;
        ph_mag <= 26'(cx_r);
        ph_ang <= cz_r - ref_a;
        if (is_va) begin
          va_ang_r <= cz_r;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/fdft_top_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module fdft_top_asserts #(
  parameter logic [23:0] NOM_TICKS_50 = 24'h01e848,
  parameter logic [23:0] NOM_TICKS_60 = 24'h0196e6
) (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               ref_sel_ab,
  input wire logic               nominal_60,
  input wire logic               in_valid,
  input wire logic               in_ready,
  input wire logic [2:0]         in_ch,
  input wire logic [15:0]        in_data,
  input wire logic               sample_req,
  input wire logic [1:0]         rate_mode,
  input wire logic [23:0]        freq_period,
  input wire logic               freq_valid,
  input wire logic               ph_valid,
  input wire logic [2:0]         ph_ch,
  input wire logic signed [23:0] ph_re,
  input wire logic signed [23:0] ph_im,
  input wire logic [25:0]        ph_mag,
  input wire logic [15:0]        ph_ang
);
  localparam logic [23:0] CALM = 24'(NOM_TICKS_50 * 3);
  logic [23:0] gap_r;
  logic [23:0] last_r;
  logic [23:0] calm_r;
  logic [27:0] seen_r;
  logic [27:0] now_w;
  logic        quiet_w;
  // ----------------------------------------------------------------
  // Sample spacing and settling
  // ----------------------------------------------------------------
  assign now_w   = {freq_valid, nominal_60, rate_mode, freq_period};
  assign quiet_w = calm_r > CALM;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_r  <= 24'h0;
      last_r <= 24'h0;
      calm_r <= 24'h0;
      seen_r <= 28'h0;
    end else begin
      gap_r  <= sample_req ? 24'h1 : gap_r + 24'h1;
      last_r <= sample_req ? gap_r : last_r;
      seen_r <= now_w;
      calm_r <= (now_w != seen_r) ? 24'h0 : calm_r + {23'h0, ~&calm_r};
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_req_pulse: assert property (sample_req |=> !sample_req)
    else $error("sample request wider than one cycle");
  a_nom_spacing: assert property (sample_req && rate_mode == 2'h0 && quiet_w
    |-> gap_r == (nominal_60 ? NOM_TICKS_60 : NOM_TICKS_50))
    else $error("nominal sample spacing wrong");
  a_track_spacing: assert property (sample_req && rate_mode == 2'h1
    && freq_valid && quiet_w |-> gap_r == (freq_period >> 5))
    else $error("tracking sample spacing wrong");
  a_hold_spacing: assert property (sample_req && rate_mode == 2'h3
    && quiet_w |-> gap_r == last_r)
    else $error("held sample spacing changed");
  a_freq_gone: assert property ((rate_mode != 2'h1)[*2] |-> !freq_valid)
    else $error("frequency valid without tracking");
  a_period_store: assert property (rate_mode == 2'h3
    && $past(rate_mode) == 2'h3 |-> $stable(freq_period))
    else $error("stored period changed in hold");
  a_ph_pulse: assert property (ph_valid |=> (!ph_valid)[*8])
    else $error("phasor strobes too close");
  a_ph_ref: assert property (ph_valid && ph_ch == 3'h0 |-> ph_ang == 16'h0)
    else $error("reference channel angle not zero");
  a_ph_latency: assert property (in_valid && in_ready
    |-> ##[15:80] ph_valid)
    else $error("no phasor after accepted word");
  a_ph_stable: assert property (!ph_valid |-> $stable(ph_mag)
    && $stable(ph_ang) && $stable(ph_ch) && $stable(ph_re)
    && $stable(ph_im))
    else $error("phasor output moved without strobe");
  c_track: cover property (sample_req && rate_mode == 2'h1 && quiet_w);
  c_hold: cover property (sample_req && rate_mode == 2'h3 && quiet_w);
  c_ch7: cover property (ph_valid && ph_ch == 3'h7);
endmodule
bind fdft_top fdft_top_asserts #(
  .NOM_TICKS_50(NOM_TICKS_50),
  .NOM_TICKS_60(NOM_TICKS_60)
) u_chk (
  .clk(clk), .nrst(nrst), .ref_sel_ab(ref_sel_ab), .nominal_60(nominal_60),
  .in_valid(in_valid), .in_ready(in_ready), .in_ch(in_ch),
  .in_data(in_data), .sample_req(sample_req), .rate_mode(rate_mode),
  .freq_period(freq_period), .freq_valid(freq_valid), .ph_valid(ph_valid),
  .ph_ch(ph_ch), .ph_re(ph_re), .ph_im(ph_im), .ph_mag(ph_mag),
  .ph_ang(ph_ang)
);
`default_nettype wire

// ==== verification/fdft_chan_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module fdft_chan_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        sample_req,
  input  wire logic        in_ready,
  input  wire logic [15:0] amp [0:7],
  input  wire logic signed [31:0] per_a,
  input  wire logic signed [31:0] per_ab,
  output var  logic        in_valid,
  output var  logic [2:0]  in_ch,
  output var  logic [15:0] in_data
);
  int now = 0;
  int tq [$];
  int t;
  // ----------------------------------------------------------------
  // Time stamp of each sample request
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    now <= now + 1;
    if (nrst === 1'b1 && sample_req === 1'b1)
      tq.push_back(now);
  end
  function automatic logic [15:0] sample(input int c, input int ts);
    real ph;
    ph = 6.2831853 * ts / ((c == 3) ? per_ab : per_a) - 2.0944 * c;
    return 16'($rtoi($itor(amp[c]) * $sin(ph)));
  endfunction
  // ----------------------------------------------------------------
  // One set of eight channel words per request
  // ----------------------------------------------------------------
  initial begin
    in_valid = 1'b0;
    in_ch    = 3'h0;
    in_data  = 16'h0;
    forever begin
      @(posedge clk);
      if (tq.size() > 0) begin
        t = tq.pop_front();
        #1;
        in_valid = 1'b1;
        for (int c = 0; c < 8; c++) begin
          in_ch   = 3'(c);
          in_data = sample(c, t);
          do @(posedge clk); while (in_ready !== 1'b1);
          #1;
        end
        in_valid = 1'b0;
        in_ch    = ~in_ch;
        in_data  = ~in_data;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/test_frequency_tracking_dft.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_frequency_tracking_dft;
  localparam int LIM = 40000;
  logic               clk;
  logic               nrst;
  logic               ref_sel_ab;
  logic               nominal_60;
  logic               in_valid;
  logic               in_ready;
  logic [2:0]         in_ch;
  logic [15:0]        in_data;
  logic               sample_req;
  logic [1:0]         rate_mode;
  logic [23:0]        freq_period;
  logic               freq_valid;
  logic               ph_valid;
  logic [2:0]         ph_ch;
  logic signed [23:0] ph_re;
  logic signed [23:0] ph_im;
  logic [25:0]        ph_mag;
  logic [15:0]        ph_ang;
  logic [15:0]        amp [0:7];
  logic [2:0]         exp_ch;
  logic [2:0]         note_q [$];
  int                 per_a;
  int                 per_ab;
  int                 fail_count;
  int                 checks_done;
  fdft_top #(
    .NOM_TICKS_50(24'h000096),
    .NOM_TICKS_60(24'h00007d)
  ) DUT (
    .clk(clk), .nrst(nrst), .ref_sel_ab(ref_sel_ab), .nominal_60(nominal_60),
    .in_valid(in_valid), .in_ready(in_ready), .in_ch(in_ch),
    .in_data(in_data), .sample_req(sample_req), .rate_mode(rate_mode),
    .freq_period(freq_period), .freq_valid(freq_valid), .ph_valid(ph_valid),
    .ph_ch(ph_ch), .ph_re(ph_re), .ph_im(ph_im), .ph_mag(ph_mag),
    .ph_ang(ph_ang)
  );
  fdft_chan_model model (
    .clk(clk), .nrst(nrst), .sample_req(sample_req), .in_ready(in_ready),
    .amp(amp), .per_a(per_a), .per_ab(per_ab), .in_valid(in_valid),
    .in_ch(in_ch), .in_data(in_data)
  );
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic settle(input int n);
    chk(32'(n < LIM), 32'h1);
    if (n >= LIM)
      end_of_test();
    #1;
  endtask
  task automatic wait_mode(input logic [1:0] m);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rate_mode !== m && n < LIM);
    settle(n);
  endtask
  task automatic wait_period(input int p);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(freq_valid === 1'b1 && freq_period > p - 170
                 && freq_period < p + 170) && n < LIM);
    settle(n);
  endtask
  task automatic mag_check(input int c);
    int          n;
    int          e;
    real         r;
    logic [15:0] a;
    n = 0;
    e = $rtoi(16.0 * 1.6468 * amp[c]);
    r = 256.0 * amp[c] * amp[c];
    a = 16'(-21845 * c);
    do begin
      @(posedge clk);
      n++;
    end while (!(ph_valid === 1'b1 && ph_ch === 3'(c) && ph_mag > e - e / 10
                 && ph_mag < e + e / 10
                 && $itor(ph_re) * ph_re + $itor(ph_im) * ph_im > 0.8 * r
                 && $itor(ph_re) * ph_re + $itor(ph_im) * ph_im < 1.2 * r
                 && ph_ang - a + 16'h0400 < 16'h0800) && n < LIM);
    settle(n);
  endtask
  // ----------------------------------------------------------------
  // Phasor order monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (nrst === 1'b1 && in_valid === 1'b1 && in_ready === 1'b1)
      note_q.push_back(in_ch);
    if (nrst === 1'b1 && ph_valid === 1'b1) begin
      if (note_q.size() == 0)
        chk(32'h1, 32'h0);
      else begin
        exp_ch = note_q.pop_front();
        chk(32'(ph_ch), 32'(exp_ch));
        if (exp_ch == 3'h0)
          chk(32'(ph_ang), 32'h0);
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst        = 1'b0;
    ref_sel_ab  = 1'b0;
    nominal_60  = 1'b0;
    fail_count  = 0;
    checks_done = 0;
    per_a       = 5120;
    per_ab      = 5120;
    void'($urandom(35931));
    foreach (amp[i])
      amp[i] = 16'(1000 + $urandom % 4000);
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    wait_mode(2'h1);
    wait_period(5120);
    mag_check(1);
    ref_sel_ab = 1'b1;
    per_ab     = 4480;
    wait_period(4480);
    ref_sel_ab = 1'b0;
    amp[0]     = 16'h0;
    wait_mode(2'h3);
    chk(32'(freq_valid), 32'h0);
    amp[1] = 16'h0;
    amp[2] = 16'h0;
    wait_mode(2'h0);
    nominal_60 = 1'b1;
    amp[0]     = 16'h0bb8;
    wait_mode(2'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
